// File: hdl/sia_allocator.sv
// Servo I/O signal allocator: APB registers, input routing, output driving
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - Each input function's 4-bit code picks circuit, inverted level, or forced state.
// - Overtravels default active high; force limits and homing default active low.
// - Latch functions route only from circuits 10..12, or forced on or off.
// - Latch codes naming circuits 13, 7, 8 or 9 are rejected, not applied.
// - Functions sharing a circuit all follow its level, each with own polarity.
// - Output functions sharing an output circuit are ORed together.
// - Output functions not evaluated in the current mode read as inactive.
// - Brake interlock output may be inverted to positive logic.
// - Output codes 1..3 pick circuits 1(2), 23(24), 25(26); 0 leaves unassigned.
module sia_allocator
   import sia_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire sia_apb_req_t          apb_req,
   output sia_apb_rsp_t               apb_rsp,
   input  wire logic [NUM_PINS-1:0]   in_pin,
   input  wire sia_mode_t             ctl_mode,
   input  wire sia_out_func_t         out_func,
   output sia_in_func_t               in_func,
   output logic      [NUM_OCIRC-1:0]  out_circ
);

   // ----------------------------------------------------------------
   // Input synchroniser
   // ----------------------------------------------------------------
   logic [NUM_PINS-1:0] pin_s1;
   logic [NUM_PINS-1:0] pin_s2;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end
      else
      begin
         pin_s1 <= in_pin;
         pin_s2 <= pin_s1;
      end
   end

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [NUM_IFN*SEL_W-1:0]   in_sel;
   logic [NUM_OFN*OSEL_W-1:0]  out_sel;
   logic [3:0]                 out_ctl;
   logic [NUM_LATCH-1:0]       reject;
   logic [31:0]                rdata;
   logic [NUM_IFN*SEL_W-1:0]   next_in_sel;
   logic [NUM_OFN*OSEL_W-1:0]  next_out_sel;
   logic [3:0]                 next_out_ctl;
   logic [NUM_LATCH-1:0]       next_reject;
   logic [NUM_LATCH-1:0]       rej_hit;
   logic [31:0]                next_rdata;
   logic                       wr_acc;
   logic                       rd_setup;
   logic                       mapped;
   logic [31:0]                status_word;

   function automatic logic latch_code_ok(input logic [3:0] code);
      latch_code_ok = (code >= CODE_LATCH_LO && code <= CODE_OFF)
                      || code >= CODE_LATCH_INV_LO;
   endfunction

   always_comb
   begin
      mapped   = apb_req.paddr == REG_IN_SEL || apb_req.paddr == REG_OUT_SEL
                 || apb_req.paddr == REG_OUT_CTL || apb_req.paddr == REG_STATUS
                 || apb_req.paddr == REG_REJECT;
      wr_acc   = apb_req.psel && apb_req.penable && apb_req.pwrite;
      rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   end

   always_comb
   begin
      status_word = '0;
      status_word[ST_PIN_LSB +: NUM_PINS]     = pin_s2;
      status_word[ST_IFN_LSB +: NUM_IFN]      = in_func;
      status_word[ST_OCIRC_LSB +: NUM_OCIRC]  = out_circ;
      status_word[ST_MODE_LSB +: 2]           = ctl_mode;
   end

   always_comb
   begin
      next_in_sel  = in_sel;
      next_out_sel = out_sel;
      next_out_ctl = out_ctl;
      rej_hit      = '0;
      if (wr_acc && apb_req.paddr == REG_IN_SEL)
      begin
         for (int f = 0; f < NUM_IFN; f++)
         begin
            // Illegal latch codes keep the old nibble so routing never breaks
            if (f >= LATCH_FIRST && !latch_code_ok(apb_req.pwdata[f*SEL_W +: SEL_W]))
            begin
               rej_hit[f - LATCH_FIRST] = 1'b1;
            end
            else
            begin
               next_in_sel[f*SEL_W +: SEL_W] = apb_req.pwdata[f*SEL_W +: SEL_W];
            end
         end
      end
      if (wr_acc && apb_req.paddr == REG_OUT_SEL)
      begin
         next_out_sel = apb_req.pwdata[NUM_OFN*OSEL_W-1:0];
      end
      if (wr_acc && apb_req.paddr == REG_OUT_CTL)
      begin
         next_out_ctl = apb_req.pwdata[3:0];
      end
      // Write one to clear; a new rejection in the same cycle wins
      next_reject = reject;
      if (wr_acc && apb_req.paddr == REG_REJECT)
      begin
         next_reject = reject & ~apb_req.pwdata[NUM_LATCH-1:0];
      end
      next_reject = next_reject | rej_hit;
   end

   always_comb
   begin
      next_rdata = rdata;
      if (rd_setup)
      begin
         case (apb_req.paddr)
            REG_IN_SEL:  next_rdata = in_sel;
            REG_OUT_SEL: next_rdata = 32'(out_sel);
            REG_OUT_CTL: next_rdata = 32'(out_ctl);
            REG_STATUS:  next_rdata = status_word;
            REG_REJECT:  next_rdata = 32'(reject);
            default:     next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         in_sel  <= IN_SEL_RST;
         out_sel <= OUT_SEL_RST;
         out_ctl <= OUT_CTL_RST;
         reject  <= '0;
         rdata   <= '0;
      end
      else
      begin
         in_sel  <= next_in_sel;
         out_sel <= next_out_sel;
         out_ctl <= next_out_ctl;
         reject  <= next_reject;
         rdata   <= next_rdata;
      end
   end

   // Read data is captured in the setup cycle, so no wait states
   always_comb
   begin
      apb_rsp.prdata  = rdata;
      apb_rsp.pready  = 1'b1;
      apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
   end

   // ----------------------------------------------------------------
   // Input function routing
   // ----------------------------------------------------------------
   logic [NUM_IFN-1:0] next_func;
   logic [NUM_IFN-1:0] func_q;

   genvar g;
   generate
      for (g = 0; g < NUM_IFN; g++)
      begin : g_ifn
         logic [3:0] code;
         logic [3:0] idx;
         logic       act_high;
         always_comb
         begin
            code     = in_sel[g*SEL_W +: SEL_W];
            act_high = IFN_DEF_HIGH[g] ^ (code >= CODE_INV_BASE);
            idx      = (code >= CODE_INV_BASE) ? code - CODE_INV_BASE : code;
            if (code == CODE_ON)
            begin
               next_func[g] = 1'b1;
            end
            else if (code == CODE_OFF)
            begin
               next_func[g] = 1'b0;
            end
            else
            begin
               // Shared circuits feed every user from the same sample
               next_func[g] = pin_s2[idx[2:0]] == act_high;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         func_q <= '0;
      end
      else
      begin
         func_q <= next_func;
      end
   end

   assign in_func = sia_in_func_t'(func_q);

   // ----------------------------------------------------------------
   // Output circuits
   // ----------------------------------------------------------------
   sia_out_mux u_out_mux
   (
      .clk       (clk),
      .nrst      (nrst),
      .func      (out_func),
      .sel       (out_sel),
      .circ_inv  (out_ctl[NUM_OCIRC-1:0]),
      .brake_pos (out_ctl[CTL_BRAKE_POS]),
      .mode      (ctl_mode),
      .circ      (out_circ)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence seq_fwd_hi_held;
      (in_pin[0] && in_sel[3:0] == 4'h0)[*3];
   endsequence

   sequence seq_fcl_lo_held;
      (!in_pin[0] && in_sel[11:8] == 4'h0)[*3];
   endsequence

   sequence seq_latch_bad_write;
      wr_acc && apb_req.paddr == REG_IN_SEL
      && apb_req.pwdata[23:20] inside {[4'h0:4'h3], [4'h9:4'hC]};
   endsequence

   chk_force_on: assert property (in_sel[3:0] == CODE_ON |=> in_func.fwd_overtravel_in)
      else $error("forced-on function not active");

   chk_force_off: assert property (in_sel[15:12] == CODE_OFF
      |=> !in_func.rev_force_limit_in)
      else $error("forced-off function active");

   chk_ot_high: assert property (seq_fwd_hi_held |=> in_func.fwd_overtravel_in)
      else $error("overtravel not active on high level");

   chk_cl_low: assert property (seq_fcl_lo_held |=> in_func.fwd_force_limit_in)
      else $error("force limit not active on low level");

   chk_latch_route: assert property ((in_sel[23:20] == 4'h4 && !pin_s2[4])
      |=> in_func.latch_in_1)
      else $error("latch not routed from circuit 10");

   chk_latch_reject: assert property (seq_latch_bad_write |=> $stable(in_sel[23:20])
      && reject[0])
      else $error("illegal latch code applied or not flagged");

   chk_shared_pin: assert property ((in_sel[3:0] == 4'h0 && in_sel[7:4] == 4'h9)
      |=> in_func.fwd_overtravel_in != in_func.rev_overtravel_in)
      else $error("shared circuit gave inconsistent functions");

   chk_sync_lag: assert property (in_sel[3:0] == 4'h0 && $stable(in_sel[3:0])
      |-> in_func.fwd_overtravel_in == $past(in_pin[0], 3))
      else $error("input not taken through two-stage sync");

   chk_unmapped: assert property ((apb_req.psel && apb_req.penable && !apb_req.pwrite
      && apb_req.paddr == 8'h14) |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
      else $error("unmapped address accepted");

   chk_reject_hold: assert property ((reject[1] && !rej_hit[1]
      && !(wr_acc && apb_req.paddr == REG_REJECT)) |=> reject[1])
      else $error("rejection flag lost");

endmodule

// File: pkg/sia_pkg.sv
// Package for the servo I/O signal allocator: constants, codes, carriers
package sia_pkg;

   // --------------------------------------------------------------
   // Sizes
   // --------------------------------------------------------------
   localparam int NUM_PINS  = 7;   // circuits 13,7,8,9,10,11,12 in that order
   localparam int NUM_IFN   = 8;
   localparam int NUM_OFN   = 9;
   localparam int NUM_OCIRC = 3;   // 1(2), 23(24), 25(26)
   localparam int SEL_W     = 4;
   localparam int OSEL_W    = 2;
   localparam int LATCH_FIRST = 5; // input functions 5..7 are the latches
   localparam int NUM_LATCH = 3;

   // --------------------------------------------------------------
   // Selector codes
   // --------------------------------------------------------------
   localparam logic [3:0] CODE_ON           = 4'h7;
   localparam logic [3:0] CODE_OFF          = 4'h8;
   localparam logic [3:0] CODE_INV_BASE     = 4'h9;
   localparam logic [3:0] CODE_LATCH_LO     = 4'h4;
   localparam logic [3:0] CODE_LATCH_INV_LO = 4'hD;
   localparam logic [1:0] OCODE_NONE        = 2'h0;

   // Functions whose default active level is high (both overtravels)
   localparam logic [NUM_IFN-1:0] IFN_DEF_HIGH = 8'h03;

   // Output function indices
   localparam int OFN_DONE  = 0;
   localparam int OFN_VCMP  = 1;
   localparam int OFN_VLT   = 5;
   localparam int OFN_BRAKE = 6;
   localparam int OFN_NEAR  = 8;

   // --------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_IN_SEL  = 8'h00;
   localparam logic [ADDR_W-1:0] REG_OUT_SEL = 8'h04;
   localparam logic [ADDR_W-1:0] REG_OUT_CTL = 8'h08;
   localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_REJECT  = 8'h10;

   localparam logic [31:0] IN_SEL_RST  = 32'h88888888;
   localparam logic [17:0] OUT_SEL_RST = 18'h00000;
   localparam logic [3:0]  OUT_CTL_RST = 4'h0;

   localparam int CTL_BRAKE_POS = 3;  // OUT_CTL bits 2:0 invert circuits
   localparam int ST_PIN_LSB    = 0;
   localparam int ST_IFN_LSB    = 8;
   localparam int ST_OCIRC_LSB  = 16;
   localparam int ST_MODE_LSB   = 20;

   // --------------------------------------------------------------
   // Types
   // --------------------------------------------------------------
   typedef enum logic [1:0] {MODE_POSITION, MODE_SPEED, MODE_FORCE} sia_mode_t;

   typedef struct packed {
      logic latch_in_3;
      logic latch_in_2;
      logic latch_in_1;
      logic homing_decel_in;
      logic rev_force_limit_in;
      logic fwd_force_limit_in;
      logic rev_overtravel_in;
      logic fwd_overtravel_in;
   } sia_in_func_t;

   typedef struct packed {
      logic near_out;
      logic warning_out;
      logic brake_interlock_out;
      logic speed_limit_out;
      logic force_limit_out;
      logic servo_ready_out;
      logic moving_out;
      logic speed_match_out;
      logic position_done_out;
   } sia_out_func_t;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } sia_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } sia_apb_rsp_t;

endpackage

// File: hdl/sia_out_mux.sv
// Output side: validity by mode, brake polarity, OR onto output circuits
`timescale 1ns/1ps
module sia_out_mux
   import sia_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic                        nrst,
   input  wire sia_out_func_t               func,
   input  wire logic [NUM_OFN*OSEL_W-1:0]   sel,
   input  wire logic [NUM_OCIRC-1:0]        circ_inv,
   input  wire logic                        brake_pos,
   input  wire sia_mode_t                   mode,
   output logic      [NUM_OCIRC-1:0]        circ
);

   logic [NUM_OFN-1:0]   state;
   logic [NUM_OCIRC-1:0] next_circ;

   always_comb
   begin
      state = func;
      // Functions not evaluated in this mode count as inactive
      if (mode != MODE_POSITION)
      begin
         state[OFN_DONE] = 1'b0;
         state[OFN_NEAR] = 1'b0;
      end
      if (mode != MODE_SPEED)
      begin
         state[OFN_VCMP] = 1'b0;
      end
      if (mode != MODE_FORCE)
      begin
         state[OFN_VLT] = 1'b0;
      end
      // Positive logic loses the fail-safe on a broken brake line
      state[OFN_BRAKE] = func.brake_interlock_out ^ brake_pos;
   end

   genvar c;
   generate
      for (c = 0; c < NUM_OCIRC; c++)
      begin : g_circ
         logic [NUM_OFN-1:0] hit;
         always_comb
         begin
            hit = '0;
            for (int f = 0; f < NUM_OFN; f++)
            begin
               hit[f] = state[f] && (sel[f*OSEL_W +: OSEL_W] == OSEL_W'(c + 1));
            end
            next_circ[c] = (|hit) ^ circ_inv[c];
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         circ <= '0;
      end
      else
      begin
         circ <= next_circ;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_or_circuit: assert property ((sel[1:0] == 2'h1 && sel[3:0] != 4'h0
      && func.position_done_out && mode == MODE_POSITION && !circ_inv[0]) |=> circ[0])
      else $error("circuit 1 not driven by OR of assigned functions");

   chk_invalid_mode: assert property ((sel == 18'h00001 && mode == MODE_SPEED
      && !circ_inv[0]) |=> !circ[0])
      else $error("position done drove a circuit in speed mode");

   chk_brake_pos: assert property ((sel[OFN_BRAKE*OSEL_W +: OSEL_W] == 2'h1
      && brake_pos && !circ_inv[0] && !func.brake_interlock_out) |=> circ[0])
      else $error("brake positive logic not applied");

   chk_unassigned: assert property ((sel == OUT_SEL_RST && circ_inv == 3'h0)
      |=> circ == 3'h0)
      else $error("unassigned functions drove a circuit");

endmodule

// File: tb/sia_host_model.sv
// Host controller model: drives sequence inputs, mode and output function states
`timescale 1ns/1ps
module sia_host_model
   import sia_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic [NUM_PINS-1:0]  pin_cmd,
   input  wire sia_mode_t            mode_cmd,
   input  wire sia_out_func_t        ofn_cmd,
   input  wire sia_in_func_t         in_func,
   input  wire logic [NUM_OCIRC-1:0] out_circ,
   output sia_mode_t                 ctl_mode,
   output sia_out_func_t             out_func,
   output logic      [NUM_PINS-1:0]  in_pin
);
   // ------------------------------------------------------------
   // Contacts and states change just after an edge, like real relays
   // ------------------------------------------------------------
   initial
   begin
      in_pin   = '0;
      ctl_mode = MODE_POSITION;
      out_func = '0;
   end

   always @(posedge clk)
   begin
      in_pin   <= pin_cmd;
      ctl_mode <= mode_cmd;
      out_func <= ofn_cmd;
   end
endmodule

// File: tb/sia_allocator_tb.sv
// Self-checking testbench for the servo I/O signal allocator
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("FAIL %0t mismatch got %h exp %h", $time, g, e); end end
module sia_allocator_tb
   import sia_pkg::*;
;
   logic                 clk = 1'b0;
   logic                 nrst = 1'b0;
   sia_apb_req_t         req = '0;
   sia_apb_rsp_t         rsp;
   logic [NUM_PINS-1:0]  pin_cmd = '0;
   sia_mode_t            mode_cmd = MODE_POSITION;
   sia_out_func_t        ofn_cmd = '0;
   logic [NUM_PINS-1:0]  in_pin;
   sia_mode_t            ctl_mode;
   sia_out_func_t        out_func;
   sia_in_func_t         in_func;
   logic [NUM_OCIRC-1:0] out_circ;
   int                   num_errors = 0;
   int                   checked = 0;
   logic [31:0]          rd;
   logic                 err;
   logic [31:0]          sel;
   logic [3:0]           lc;
   logic [7:0]           exp_in;
   logic [2:0]           exp_oc;

   always #25 clk = ~clk;

   sia_allocator i_dut (.clk(clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
      .in_pin(in_pin), .ctl_mode(ctl_mode), .out_func(out_func),
      .in_func(in_func), .out_circ(out_circ));

   sia_host_model i_host (.clk(clk), .pin_cmd(pin_cmd), .mode_cmd(mode_cmd),
      .ofn_cmd(ofn_cmd), .in_func(in_func), .out_circ(out_circ),
      .ctl_mode(ctl_mode), .out_func(out_func), .in_pin(in_pin));

   // ------------------------------------------------------------
   // Bus cycles and helpers
   // ------------------------------------------------------------
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= a;
      req.pwdata  <= d;
      @(posedge clk);
      req.penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (rsp.pready === 1'b1)
            break;
      end
      rd  = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      if (n == 20)
      begin
         num_errors++;
         $display("FAIL %0t apb ready timeout", $time);
         summarize();
      end
   endtask

   // Long enough for two sync stages plus the output register
   task automatic settle();
      repeat (5) @(posedge clk);
      #1;
   endtask

   function automatic logic efn(int f, logic [3:0] c, logic [6:0] p);
      logic lvl;
      if (c == CODE_ON)
         return 1'b1;
      if (c == CODE_OFF)
         return 1'b0;
      lvl = p[c < CODE_INV_BASE ? c : c - CODE_INV_BASE];
      return (IFN_DEF_HIGH[f] ? lvl : ~lvl) ^ (c >= CODE_INV_BASE);
   endfunction

   function automatic logic ovalid(int f, int m);
      if (f == OFN_DONE || f == OFN_NEAR)
         return m == 0;
      if (f == OFN_VCMP)
         return m == 1;
      if (f == OFN_VLT)
         return m == 2;
      return 1'b1;
   endfunction

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      apb(1'b0, REG_IN_SEL, 32'h0);
      `CHK(rd, IN_SEL_RST)
      apb(1'b0, REG_OUT_SEL, 32'h0);
      `CHK(rd, 32'h00000000)
      apb(1'b0, 8'h14, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h00000000)
      // Every code on the first five functions, only legal codes on the latches, two pin patterns
      for (int p = 0; p < 2; p++)
         for (int c = 0; c < 16; c++)
         begin
            pin_cmd <= p ? 7'h2A : 7'h55;
            lc = (c inside {[4:8], [13:15]}) ? 4'(c) : CODE_OFF;
            sel = {lc, lc, lc, {5{4'(c)}}};
            apb(1'b1, REG_IN_SEL, sel);
            settle();
            for (int f = 0; f < NUM_IFN; f++)
               exp_in[f] = efn(f, sel[4*f +: 4], p ? 7'h2A : 7'h55);
            `CHK(in_func, exp_in)
         end
      // Latch codes naming circuits 13 or 9 are refused
      apb(1'b1, REG_IN_SEL, 32'h45688888);
      apb(1'b1, REG_IN_SEL, 32'h39C77777);
      apb(1'b0, REG_IN_SEL, 32'h0);
      `CHK(rd, 32'h45677777)
      apb(1'b0, REG_REJECT, 32'h0);
      `CHK(rd[2:0], 3'h7)
      apb(1'b1, REG_REJECT, 32'h7);
      apb(1'b0, REG_REJECT, 32'h0);
      `CHK(rd[2:0], 3'h0)
      // Pin seen by functions only after the two sync stages
      // Reverse overtravel shares circuit 13 with inverted level
      apb(1'b1, REG_IN_SEL, 32'h88888890);
      pin_cmd <= 7'h00;
      settle();
      pin_cmd <= 7'h01;
      @(posedge clk);
      repeat (2) @(posedge clk);
      #1;
      `CHK(in_func.fwd_overtravel_in, 1'b0)
      `CHK(in_func.rev_overtravel_in, 1'b1)
      @(posedge clk);
      #1;
      `CHK(in_func.fwd_overtravel_in, 1'b1)
      `CHK(in_func.rev_overtravel_in, 1'b0)
      // Each output function on each circuit code in each mode
      for (int f = 0; f < NUM_OFN; f++)
         for (int c = 0; c < 4; c++)
         begin
            apb(1'b1, REG_OUT_SEL, 32'(c) << (2 * f));
            for (int m = 0; m < 3; m++)
            begin
               ofn_cmd  <= sia_out_func_t'(9'(1) << f);
               mode_cmd <= sia_mode_t'(m);
               settle();
               exp_oc = (c != 0 && ovalid(f, m)) ? 3'(1) << (c - 1) : 3'h0;
               `CHK(out_circ, exp_oc)
            end
         end
      // Two functions sharing circuit 23(24)
      apb(1'b1, REG_OUT_SEL, 32'h000000A0);
      for (int v = 0; v < 4; v++)
      begin
         ofn_cmd <= sia_out_func_t'(9'(v) << 2);
         settle();
         `CHK(out_circ, (v != 0) ? 3'h2 : 3'h0)
      end
      // Brake positive logic and circuit inversion
      apb(1'b1, REG_OUT_SEL, 32'h00001000);
      apb(1'b1, REG_OUT_CTL, 32'h00000008);
      ofn_cmd <= '0;
      settle();
      `CHK(out_circ, 3'h1)
      apb(1'b1, REG_OUT_CTL, 32'h0000000C);
      ofn_cmd <= sia_out_func_t'(9'h040);
      settle();
      `CHK(out_circ, 3'h4)
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK(rd, 32'h00240101)
      summarize();
   end
endmodule
